// file: verilog/asd_diag.sv
`timescale 1ns/10ps
module asd_diag
(
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire asd_pkg::asd_ctrl_type ctrlWord,
  input  wire logic [12:0]           angle,
  input  wire logic [6:0]            temperature,
  input  wire logic [12:0]           thresholdAngle,
  input  wire logic [7:0]            lowerClampLevel,
  input  wire logic [7:0]            upperClampLevel,
  input  wire logic                  oscTick,
  input  wire logic                  wdFeedValid,
  input  wire logic [7:0]            wdFeedKey,
  input  wire logic                  tempWarn,
  input  wire logic                  tempShutdown,
  input  wire logic [11:0]           magExpected,
  input  wire logic [11:0]           magMeasured,
  input  wire logic                  sampleValid,
  input  wire logic [7:0]            readback1,
  input  wire logic [7:0]            readback2,
  input  wire logic                  readbackValid,
  input  wire logic                  crcByteValid,
  input  wire logic [7:0]            crcByte,
  input  wire logic                  crcBlockEnd,
  output logic                       analogMode,
  output logic                       out1Hiz,
  output logic                       out2Hiz,
  output logic [7:0]                 out1Level,
  output logic [7:0]                 out2Level,
  output asd_pkg::asd_word_type      serialWord,
  output logic                       serialHiz,
  output logic [6:0]                 errorStatus
);

  // Deviation limits per selector
  function automatic logic [11:0] inLimit(input logic [1:0] s);
    inLimit = 12'h020 << s;
  endfunction

  function automatic logic [7:0] outLimit(input logic [1:0] s);
    outLimit = 8'h04 << s;
  endfunction

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ asd_pkg::CRC_POLY_REFL) : (r >> 1);
    end
    crcStep = r;
  endfunction

  logic [2:0]          mode;
  logic                isAnalog;
  localparam int       NUMS = asd_pkg::NUM_SRC;
  logic [NUMS-1:0]     detect;
  logic [2:0]          cnt_reg  [NUMS];
  logic [2:0]          cnt_next [NUMS];
  logic [NUMS-1:0]     active;
  logic [NUMS-1:0]     latched_reg;
  logic [NUMS-1:0]     latched_next;
  logic [NUMS-1:0]     latchable;
  logic [15:0]         crc_reg;
  logic [15:0]         crc_next;
  logic                crcBad_reg;
  logic                crcBad_next;
  logic [15:0]         wdog_reg;
  logic [15:0]         wdog_next;
  logic                wdArmed_reg;
  logic                wdArmed_next;
  logic [7:0]          mono_reg;
  logic [7:0]          mono_next;
  logic [11:0]         magDiff;
  logic [7:0]          exp1;
  logic [7:0]          exp2;
  logic [7:0]          d1;
  logic [7:0]          d2;
  logic [7:0]          lvl1;
  logic [7:0]          lvl2;
  logic                anHiz;
  logic                serHiz;
  logic                serFlag;
  logic [1:0]          ecode;
  logic [12:0]         angOut;
  asd_pkg::asd_word_type wordNext;

  assign mode     = ctrlWord.outputModeSel;
  assign isAnalog = mode[2];

  // CRC engine and watchdog, oscillator monostable
  always_comb
  begin
    crc_next     = crc_reg;
    crcBad_next  = crcBad_reg;
    wdog_next    = (wdog_reg == asd_pkg::WDOG_LIMIT) ? wdog_reg : wdog_reg + 16'h0001;
    wdArmed_next = wdArmed_reg;
    mono_next    = (mono_reg == asd_pkg::MONO_LIMIT) ? mono_reg : mono_reg + 8'h01;
    if (crcByteValid)
      crc_next = crcStep(crc_reg, crcByte);
    if (crcBlockEnd)
    begin
      crcBad_next = (crc_next != asd_pkg::CRC_GOOD);
      crc_next    = asd_pkg::CRC_INIT;
    end
    if (wdFeedValid)
    begin
      if (wdFeedKey == asd_pkg::WD_KEY1)
        wdArmed_next = 1'b1;
      else if (wdFeedKey == asd_pkg::WD_KEY2 && wdArmed_reg)
      begin
        wdArmed_next = 1'b0;
        wdog_next    = 16'h0000;
      end
      else
        wdArmed_next = 1'b0;
    end
    if (oscTick)
      mono_next = 8'h00;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      crc_reg     <= asd_pkg::CRC_INIT;
      crcBad_reg  <= 1'b0;
      wdog_reg    <= 16'h0000;
      wdArmed_reg <= 1'b0;
      mono_reg    <= 8'h00;
    end
    else
    begin
      crc_reg     <= crc_next;
      crcBad_reg  <= crcBad_next;
      wdog_reg    <= wdog_next;
      wdArmed_reg <= wdArmed_next;
      mono_reg    <= mono_next;
    end
  end

  // Raw detections
  always_comb
  begin
    magDiff = (magExpected > magMeasured) ? magExpected - magMeasured
                                          : magMeasured - magExpected;
    exp1 = out1Level;
    exp2 = out2Level;
    d1   = (readback1 > exp1) ? readback1 - exp1 : exp1 - readback1;
    d2   = (readback2 > exp2) ? readback2 - exp2 : exp2 - readback2;
    detect = '0;
    detect[asd_pkg::SRC_OSC]  = (mono_reg == asd_pkg::MONO_LIMIT);
    detect[asd_pkg::SRC_CRC]  = crcBad_reg;
    detect[asd_pkg::SRC_WDOG] = (wdog_reg == asd_pkg::WDOG_LIMIT);
    detect[asd_pkg::SRC_IN]   = sampleValid
                                && (magDiff > inLimit(ctrlWord.inputDevSel));
    detect[asd_pkg::SRC_OUT]  = isAnalog && readbackValid
                                && ((d1 > outLimit(ctrlWord.readbackBoundSel))
                                || (mode == asd_pkg::MODE_AN_INV
                                && d2 > outLimit(ctrlWord.readbackBoundSel)));
    detect[asd_pkg::SRC_TWRN] = tempWarn;
    detect[asd_pkg::SRC_TSD]  = tempShutdown;
    latchable = '0;
    latchable[asd_pkg::SRC_OSC]  = 1'b1;
    latchable[asd_pkg::SRC_CRC]  = isAnalog;
    latchable[asd_pkg::SRC_WDOG] = !isAnalog;
    latchable[asd_pkg::SRC_TSD]  = !isAnalog;
  end

  // Per-source occurrence counters
  genvar g;
  generate
    for (g = 0; g < NUMS; g++)
    begin : gSrc
      always_comb
      begin
        if (!detect[g])
          cnt_next[g] = asd_pkg::CNT_RESET;
        else if (cnt_reg[g] < ctrlWord.errCount)
          cnt_next[g] = cnt_reg[g] + 3'h1;
        else
          cnt_next[g] = ctrlWord.errCount;
        active[g]       = detect[g] && (cnt_reg[g] >= ctrlWord.errCount);
        latched_next[g] = latched_reg[g] || (active[g] && latchable[g]);
      end

      always_ff @(posedge sys_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          cnt_reg[g]     <= asd_pkg::CNT_RESET;
          latched_reg[g] <= 1'b0;
        end
        else
        begin
          cnt_reg[g]     <= cnt_next[g];
          latched_reg[g] <= latched_next[g];
        end
      end
    end
  endgenerate

  // Output decisions
  always_comb
  begin
    anHiz = (|latched_reg) || active[asd_pkg::SRC_OSC] || active[asd_pkg::SRC_CRC]
            || active[asd_pkg::SRC_WDOG] || active[asd_pkg::SRC_IN]
            || active[asd_pkg::SRC_OUT] || active[asd_pkg::SRC_TSD];
    serHiz = (|latched_reg) || active[asd_pkg::SRC_OSC] || active[asd_pkg::SRC_WDOG]
             || active[asd_pkg::SRC_TSD];
    serFlag = active[asd_pkg::SRC_CRC] || active[asd_pkg::SRC_IN]
              || active[asd_pkg::SRC_TWRN];
    if (active[asd_pkg::SRC_CRC])
      ecode = asd_pkg::ECODE_CRC;
    else if (active[asd_pkg::SRC_IN])
      ecode = asd_pkg::ECODE_INPUT;
    else
      ecode = asd_pkg::ECODE_TEMP;
    angOut = (mode == asd_pkg::MODE_SER_CMPL) ? ~angle : angle;
    wordNext.errFlag = serFlag;
    wordNext.angle   = serFlag ? {angOut[12:2], ecode} : angOut;
    wordNext.temp    = (mode == asd_pkg::MODE_SER_CMPL) ? ~temperature : temperature;
    lvl1 = 8'(lowerClampLevel
           + 8'((16'(upperClampLevel - lowerClampLevel) * 16'(angle[12:5])) >> 8));
    case (mode)
      asd_pkg::MODE_AN_INV:  lvl2 = 8'(upperClampLevel + lowerClampLevel - lvl1);
      asd_pkg::MODE_AN_HALF: lvl2 = {1'b0, lvl1[7:1]};
      asd_pkg::MODE_AN_CMP:  lvl2 = (angle > thresholdAngle) ? upperClampLevel
                                                             : lowerClampLevel;
      default:               lvl2 = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      analogMode  <= 1'b0;
      out1Hiz     <= 1'b1;
      out2Hiz     <= 1'b1;
      out1Level   <= 8'h00;
      out2Level   <= 8'h00;
      serialWord  <= '0;
      serialHiz   <= 1'b1;
      errorStatus <= '0;
    end
    else
    begin
      analogMode  <= isAnalog;
      out1Hiz     <= isAnalog ? anHiz : 1'b1;
      out2Hiz     <= isAnalog ? (anHiz || mode == asd_pkg::MODE_AN_OFF) : 1'b1;
      out1Level   <= lvl1;
      out2Level   <= lvl2;
      serialWord  <= wordNext;
      serialHiz   <= isAnalog ? 1'b1 : serHiz;
      errorStatus <= active | latched_reg;
    end
  end

  AST_OSC_LATCH: assert property (@(posedge sys_clk) disable iff (!nrst)
    latched_reg[asd_pkg::SRC_OSC] |=> ##1 (out1Hiz && serialHiz))
    else $error("oscillator latch did not tri-state");
  AST_WARN_ANALOG: assert property (@(posedge sys_clk) disable iff (!nrst)
    (isAnalog && detect == 7'h20 && latched_reg == '0) |=> !out1Hiz)
    else $error("warning affected analog output");
  AST_FLAG_CODE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (active[asd_pkg::SRC_CRC] && !isAnalog) |=> (serialWord.errFlag
      && serialWord.angle[1:0] == asd_pkg::ECODE_CRC))
    else $error("crc flag or code missing");
  AST_LATCH_STICKY: assert property (@(posedge sys_clk) disable iff (!nrst)
    latched_reg[asd_pkg::SRC_OSC] |=> latched_reg[asd_pkg::SRC_OSC])
    else $error("latched error cleared");
  AST_WDOG_FEED: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wdFeedValid && wdFeedKey == asd_pkg::WD_KEY2 && wdArmed_reg) |=> wdog_reg == 16'h0000)
    else $error("watchdog not reloaded");
  AST_CNT_SAT: assert property (@(posedge sys_clk) disable iff (!nrst)
    cnt_reg[asd_pkg::SRC_IN] <= ctrlWord.errCount || $changed(ctrlWord))
    else $error("counter passed threshold");
  AST_HIZ_MODE4: assert property (@(posedge sys_clk) disable iff (!nrst)
    (mode == asd_pkg::MODE_AN_OFF) [*2] |-> out2Hiz)
    else $error("second output driven in mode four");
  AST_CMPL: assert property (@(posedge sys_clk) disable iff (!nrst)
    (mode == asd_pkg::MODE_SER_CMPL && !serFlag) |=> serialWord.angle == ~$past(angle))
    else $error("complement wrong");

endmodule

// file: verilog/asd_pkg.sv
package asd_pkg;

  // Output mode codes
  localparam logic [2:0] MODE_SER_STD  = 3'h0;
  localparam logic [2:0] MODE_SER_CMPL = 3'h1;
  localparam logic [2:0] MODE_AN_INV   = 3'h4;
  localparam logic [2:0] MODE_AN_HALF  = 3'h5;
  localparam logic [2:0] MODE_AN_CMP   = 3'h6;
  localparam logic [2:0] MODE_AN_OFF   = 3'h7;

  // Error codes in the two low angle bits
  localparam logic [1:0] ECODE_CRC    = 2'h1;
  localparam logic [1:0] ECODE_INPUT  = 2'h2;
  localparam logic [1:0] ECODE_TEMP   = 2'h3;

  // CRC-16 (HDLC, reflected polynomial 0x8408), init all ones
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [15:0] CRC_GOOD      = 16'hf0b8;

  // Reset values, sizes and watchdog keys
  localparam logic [2:0]  CNT_RESET     = 3'h0;
  localparam int          NUM_SRC       = 7;
  localparam logic [15:0] WDOG_LIMIT    = 16'h0fff;
  localparam logic [7:0]  MONO_LIMIT    = 8'h3f;
  localparam logic [7:0]  WD_KEY1       = 8'ha5;
  localparam logic [7:0]  WD_KEY2       = 8'h5a;

  // Error source indices
  localparam int SRC_OSC  = 0;
  localparam int SRC_CRC  = 1;
  localparam int SRC_WDOG = 2;
  localparam int SRC_IN   = 3;
  localparam int SRC_OUT  = 4;
  localparam int SRC_TWRN = 5;
  localparam int SRC_TSD  = 6;

  typedef struct packed {
    logic [1:0] inputDevSel;
    logic [1:0] readbackBoundSel;
    logic [2:0] outputModeSel;
    logic [2:0] errCount;
  } asd_ctrl_type;

  typedef struct packed {
    logic        errFlag;
    logic [12:0] angle;
    logic [6:0]  temp;
  } asd_word_type;

endpackage

// file: tb/asd_load_model.sv
`timescale 1ns/10ps
module asd_load_model
(
  input  wire logic       sys_clk,
  input  wire logic       out1Hiz,
  input  wire logic       out2Hiz,
  input  wire logic [7:0] out1Level,
  input  wire logic [7:0] out2Level,
  input  wire logic [7:0] rbOffset,
  output logic [7:0]      readback1,
  output logic [7:0]      readback2,
  output logic            readbackValid
);
  // Pull-up holds a released pin at the top of the range
  // Converter follows the pin level without delay
  always_comb
  begin
    readback1     = (out1Hiz ? 8'hff : out1Level) + rbOffset;
    readback2     = (out2Hiz ? 8'hff : out2Level) + rbOffset;
    readbackValid = ~out1Hiz;
  end
endmodule

// file: tb/angle_sensor_diagnosis_output_mode_test.sv
`timescale 1ns/10ps
module angle_sensor_diagnosis_output_mode_test;
  logic                  sys_clk, nrst, oscRun, wdRun, tempWarn, tempShutdown, hz;
  logic                  sampleValid, crcByteValid, crcBlockEnd, readbackValid;
  logic                  analogMode, out1Hiz, out2Hiz, serialHiz;
  logic                  oscTick = 0;
  logic                  wdFeedValid = 0;
  logic [7:0]            wdFeedKey = 8'h00;
  logic [7:0]            lowerClampLevel, upperClampLevel, readback1, readback2;
  logic [7:0]            crcByte, rbOffset, out1Level, out2Level;
  logic [12:0]           angle, thresholdAngle;
  logic [6:0]            temperature, errorStatus;
  logic [11:0]           magExpected, magMeasured;
  asd_pkg::asd_ctrl_type ctrlWord;
  asd_pkg::asd_word_type serialWord;
  int                    mismatches, samples_checked;
  int                    cyc = 0;

  asd_diag DUT
  (
    .sys_clk, .nrst, .ctrlWord, .angle, .temperature, .thresholdAngle, .lowerClampLevel,
    .upperClampLevel, .oscTick, .wdFeedValid, .wdFeedKey, .tempWarn, .tempShutdown,
    .magExpected, .magMeasured, .sampleValid, .readback1, .readback2, .readbackValid,
    .crcByteValid, .crcByte, .crcBlockEnd, .analogMode, .out1Hiz, .out2Hiz, .out1Level,
    .out2Level, .serialWord, .serialHiz, .errorStatus
  );
  asd_load_model LOAD
  (
    .sys_clk, .out1Hiz, .out2Hiz, .out1Level, .out2Level, .rbOffset, .readback1,
    .readback2, .readbackValid
  );

  initial
  begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Oscillator ticks and two-step watchdog feeds
  always @(negedge sys_clk)
  begin
    cyc <= cyc + 1;
    oscTick <= oscRun && (cyc % 8 == 0);
    wdFeedValid <= wdRun && (cyc % 1000 < 2);
    wdFeedKey <= (cyc % 1000 == 0) ? 8'ha5 : 8'h5a;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic rst();
    nrst = 0;
    wt(16);
    nrst = 1;
    wt(2);
  endtask

  task automatic ser(input logic f, input logic [1:0] code);
    chk(serialWord.errFlag, f);
    chk(serialWord.angle, f ? {angle[12:2], code} : angle);
  endtask

  function automatic logic [15:0] crcf(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    return c;
  endfunction

  task automatic blk(input logic bad);
    logic [15:0] c;
    c = 16'hffff;
    crcByteValid = 1;
    for (int i = 0; i < 4; i++)
    begin
      crcByte = 8'h31 + i[7:0];
      c = crcf(c, crcByte);
      wt(1);
    end
    c = ~c ^ {15'h0, bad};
    crcByte = c[7:0];
    wt(1);
    crcByte = c[15:8];
    crcBlockEnd = 1;
    wt(1);
    {crcByteValid, crcBlockEnd} = 2'h0;
    wt(2);
  endtask

  task automatic t_warn();
    ctrlWord.outputModeSel = 3'h0;
    tempWarn = 1;
    wt(3);
    ser(1, 2'h3);
    ctrlWord.outputModeSel = 3'h4;
    wt(3);
    chk({out1Hiz, out2Hiz}, 2'h0);
    tempWarn = 0;
    ctrlWord.outputModeSel = 3'h0;
    wt(3);
    ser(0, 2'h0);
  endtask

  task automatic t_mode();
    for (int i = 0; i < 8; i++)
    begin
      if (i == 2 || i == 3)
        continue;
      ctrlWord.outputModeSel = i[2:0];
      wt(3);
      chk(analogMode, i[2]);
      if (i < 2)
      begin
        chk(serialWord.angle, angle ^ {13{i == 1}});
        chk(serialWord.temp, temperature ^ {7{i == 1}});
      end
      else
      begin
        chk({out1Hiz, out2Hiz}, {1'b0, i == 7});
        chk(out1Level >= 8'h20 && out1Level <= 8'he0, 1);
      end
      if (i == 5)
        chk(out2Level, out1Level >> 1);
    end
    ctrlWord.outputModeSel = 3'h6;
    wt(3);
    chk(out2Level, upperClampLevel);
    angle = 13'h0800;
    wt(3);
    chk(out2Level, lowerClampLevel);
    angle = 13'h1234;
  endtask

  task automatic t_input();
    ctrlWord.outputModeSel = 3'h0;
    ctrlWord.inputDevSel = 2'h1;
    magMeasured = 12'h140;
    wt(3);
    ser(0, 2'h0);
    magMeasured = 12'h141;
    wt(3);
    ser(1, 2'h2);
    ctrlWord.outputModeSel = 3'h4;
    wt(3);
    chk({out1Hiz, out2Hiz}, 2'h3);
    magMeasured = 12'h100;
    wt(4);
    chk({out1Hiz, out2Hiz}, 2'h0);
  endtask

  task automatic t_count();
    ctrlWord.outputModeSel = 3'h0;
    ctrlWord.errCount = 3'h3;
    tempWarn = 1;
    wt(2);
    tempWarn = 0;
    wt(3);
    ser(0, 2'h0);
    tempWarn = 1;
    wt(6);
    ser(1, 2'h3);
    tempWarn = 0;
    ctrlWord.errCount = 3'h0;
    wt(3);
  endtask

  task automatic t_rb();
    rbOffset = 8'h05;
    wt(4);
    chk(errorStatus[4], 0);
    ctrlWord.outputModeSel = 3'h4;
    rbOffset = 8'h04;
    wt(4);
    chk({out1Hiz, out2Hiz}, 2'h0);
    ctrlWord.readbackBoundSel = 2'h1;
    rbOffset = 8'h08;
    wt(4);
    chk({out1Hiz, out2Hiz}, 2'h0);
    ctrlWord.readbackBoundSel = 2'h0;
    rbOffset = 8'h05;
    hz = 0;
    repeat (10)
    begin
      wt(1);
      hz = hz | (out1Hiz & out2Hiz);
    end
    chk(hz, 1);
    rbOffset = 8'h00;
    rst();
  endtask

  task automatic t_crc();
    ctrlWord.outputModeSel = 3'h0;
    blk(1);
    ser(1, 2'h1);
    blk(0);
    ser(0, 2'h0);
    ctrlWord.outputModeSel = 3'h4;
    blk(1);
    chk({out1Hiz, out2Hiz}, 2'h3);
    blk(0);
    chk({out1Hiz, out2Hiz}, 2'h3);
    rst();
    chk({out1Hiz, out2Hiz}, 2'h0);
  endtask

  task automatic t_tsd();
    ctrlWord.outputModeSel = 3'h0;
    tempShutdown = 1;
    wt(3);
    chk(serialHiz, 1);
    tempShutdown = 0;
    wt(3);
    chk(serialHiz, 1);
    ctrlWord.outputModeSel = 3'h4;
    rst();
    tempShutdown = 1;
    wt(3);
    chk({out1Hiz, out2Hiz}, 2'h3);
    tempShutdown = 0;
    wt(4);
    chk({out1Hiz, out2Hiz}, 2'h0);
  endtask

  task automatic t_wd_osc();
    ctrlWord.outputModeSel = 3'h0;
    wdRun = 0;
    wt(4200);
    chk({serialHiz, errorStatus[2]}, 2'h3);
    wdRun = 1;
    ctrlWord.outputModeSel = 3'h4;
    rst();
    oscRun = 0;
    wt(100);
    chk({out1Hiz, out2Hiz}, 2'h3);
    oscRun = 1;
    wt(10);
    chk({out1Hiz, out2Hiz, errorStatus[0]}, 3'h7);
  endtask

  initial
  begin
    #1000000;
    mismatches++;
    test_done();
  end

  initial
  begin
    {nrst, tempWarn, tempShutdown, crcByteValid, crcBlockEnd, crcByte, rbOffset} = '0;
    {oscRun, wdRun, sampleValid} = 3'h7;
    ctrlWord = '0;
    angle = 13'h1234;
    temperature = 7'h2b;
    thresholdAngle = 13'h1000;
    lowerClampLevel = 8'h20;
    upperClampLevel = 8'he0;
    magExpected = 12'h100;
    magMeasured = 12'h100;
    rst();
    t_warn();
    t_mode();
    t_input();
    t_count();
    t_rb();
    t_crc();
    t_tsd();
    t_wd_osc();
    test_done();
  end
endmodule
